// [verilog/ism_consts.svh]
// shared constants of the serial memory slave: widths, field positions, bit counts
// Contract
// - a slave address with direction bit 0 starts a write: address bytes then data
// - every data byte written with write protect low is acknowledged and stored at the next location
// - the write address counter wraps from the last location back to zero
// - there is no busy time; an address probe is always acknowledged
// - a data byte is committed after its eighth bit and before its acknowledge
// - START or STOP before the eighth bit aborts the byte, location unchanged
// - no page buffering; each byte goes straight to its location
// - with write protect high, data bytes are refused and the array is unchanged
// - a refused protected byte leaves the address counter where it was
// - write protect low enables writes; a floating pin reads as low
// - a read address starts shifting the current location on the next clock
// - each read byte advances the address and prefetches the next; a master acknowledge sends it
// - STOP or START in the ninth clock of a read ends it and frees the data line
// - an unterminated read keeps driving further bytes onto the data line
// - the read address wraps from the last location to zero
// - the two address bytes of a write are loaded and acknowledged, data or not
// - random read: write header, address bytes, repeated START, read header
// - slave address type bits and select bits must match to respond
// - the address is two bytes; the top three bits are ignored
// - all bytes travel most significant bit first
// - a no-acknowledge aborts the operation and waits to be addressed again
`ifndef ISM_CONSTS_SVH
`define ISM_CONSTS_SVH

`define ISM_ADDR_W 13
`define ISM_FIFO_DEPTH 4
`define ISM_BIT_LAST 4'h7
`define ISM_BIT_ACK 4'h8
`define ISM_BIT_WAIT 4'h9
`define ISM_SA_TYPE_HI 7
`define ISM_SA_TYPE_LO 4
`define ISM_SA_SEL_HI 3
`define ISM_SA_SEL_LO 1
`define ISM_SA_DIR 0

`endif

// [verilog/ism_pkg.sv]
// types of the serial memory slave
package ism_pkg;
    // gray codes along idle, header, address high, address low, write, read
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_DEV = 3'h1,
        ST_AHI = 3'h3,
        ST_ALO = 3'h2,
        ST_WDAT = 3'h6,
        ST_RDAT = 3'h7
    } ism_state_t;
endpackage : ism_pkg

// [verilog/ism_stream_if.sv]
// valid/ready word stream between the slave core and its write queue
`timescale 1ns/1ps
interface ism_stream_if #(
    parameter int W = 8
) ();
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : ism_stream_if

// [verilog/ism_fifo.sv]
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = `ISM_FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    ism_stream_if.snk fill_if,
    ism_stream_if.src drain_if
);
    localparam int PW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_chk
        $error("fifo depth must be a power of two, at least two");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] cnt_ff;

    // handshakes and honest full / empty
    wire do_wr = fill_if.valid & fill_if.ready;
    wire do_rd = drain_if.valid & drain_if.ready;
    assign fill_if.ready = (cnt_ff != (PW+1)'(DEPTH));
    assign drain_if.valid = (cnt_ff != '0);
    assign drain_if.data = mem_ff[rd_ptr_ff];

    // pointers and fill count; pointers wrap naturally at the power of two
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            wr_ptr_ff <= do_wr ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
            rd_ptr_ff <= do_rd ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
            cnt_ff <= cnt_ff + (PW+1)'(do_wr) - (PW+1)'(do_rd);
        end
    end

    // storage needs no reset: a slot is only read after it was written
    always_ff @(posedge clk_i) begin
        if (do_wr) begin
            mem_ff[wr_ptr_ff] <= fill_if.data;
        end
    end
endmodule : ism_fifo

// [verilog/ism_top.sv]
// two-wire serial memory slave: bus front end, address latch, array and write queue
`timescale 1ns/1ps
`include "ism_consts.svh"
module ism_top #(
    parameter int ADDR_W = `ISM_ADDR_W,
    parameter int FIFO_DEPTH = `ISM_FIFO_DEPTH,
    parameter logic [3:0] DEV_TYPE = 4'h6 // arbitrary type code, set per product
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic [2:0] chip_select_pins_i,
    input wire logic wp_i
);
    localparam int WORD_W = ADDR_W + 8;
    localparam int HI_W = ADDR_W - 8;
    localparam int MEM_DEPTH = 1 << ADDR_W;

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (ADDR_W < 9 || ADDR_W > 16) begin : g_addr_chk
        $error("address width must lie between 9 and 16 bits");
    end

    // address step shared by write and read; wraps at the top of the array
    function automatic logic [ADDR_W-1:0] addr_next(input logic [ADDR_W-1:0] a);
        return a + 1'b1;
    endfunction : addr_next

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_sync_ff;
    logic [1:0] sda_sync_ff;
    logic [1:0] wp_sync_ff;
    logic [2:0] cs_meta_ff;
    logic [2:0] cs_sync_ff;
    logic scl_d_ff;
    logic sda_d_ff;

    // two flops per pin, a third stage for edge detection
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_ff <= 2'h3;
            sda_sync_ff <= 2'h3;
            wp_sync_ff <= 2'h0;
            cs_meta_ff <= 3'h0;
            cs_sync_ff <= 3'h0;
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_sync_ff <= {scl_sync_ff[0], scl_i};
            sda_sync_ff <= {sda_sync_ff[0], sda_i};
            wp_sync_ff <= {wp_sync_ff[0], wp_i};
            cs_meta_ff <= chip_select_pins_i;
            cs_sync_ff <= cs_meta_ff;
            scl_d_ff <= scl_sync_ff[1];
            sda_d_ff <= sda_sync_ff[1];
        end
    end

    // clock edges and bus conditions from synchronised samples
    wire scl_s = scl_sync_ff[1];
    wire sda_s = sda_sync_ff[1];
    wire wp_s = wp_sync_ff[1]; // pad pull-down: floating pin arrives as low
    wire scl_rise = scl_s & ~scl_d_ff;
    wire scl_fall = ~scl_s & scl_d_ff;
    wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
    wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ism_pkg::ism_state_t state_ff;
    ism_pkg::ism_state_t nxt_state;
    logic [3:0] bit_cnt_ff;
    logic [3:0] nxt_bit_cnt;
    logic [7:0] shift_ff;
    logic [7:0] nxt_shift;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [HI_W-1:0] hi_ff;
    logic [HI_W-1:0] nxt_hi;
    logic rd_ff;
    logic nxt_rd;
    logic ack_pend_ff;
    logic nxt_ack_pend;
    logic ack_phase_ff;
    logic nxt_ack_phase;
    logic drive_ff;
    logic nxt_drive;
    logic fetch_ff;
    logic nxt_fetch;
    logic [7:0] tx_ff;
    logic sda_o_ff;
    logic [7:0] mem_ff [MEM_DEPTH];

    ism_stream_if #(.W(WORD_W)) wr_if ();
    ism_stream_if #(.W(WORD_W)) mem_if ();

    // ------------------------------------------------------------
    // byte decoding
    // ------------------------------------------------------------
    // shift in msb first, the new bit lands at the bottom
    wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
    wire rx_state = (state_ff == ism_pkg::ST_DEV) | (state_ff == ism_pkg::ST_AHI)
                  | (state_ff == ism_pkg::ST_ALO) | (state_ff == ism_pkg::ST_WDAT);
    wire rx_bit = scl_rise & rx_state & ~ack_phase_ff & ~ack_pend_ff;
    wire byte_done = rx_bit & (bit_cnt_ff == `ISM_BIT_LAST);
    // no busy flag exists, so a matching header is always answered
    wire dev_match = (rx_byte[`ISM_SA_TYPE_HI:`ISM_SA_TYPE_LO] == DEV_TYPE)
                   & (rx_byte[`ISM_SA_SEL_HI:`ISM_SA_SEL_LO] == cs_sync_ff);
    // a full queue is refused like a protected byte rather than lost
    wire wr_ok = ~wp_s & wr_if.ready;
    wire in_wdat = (state_ff == ism_pkg::ST_WDAT);
    wire in_dev = (state_ff == ism_pkg::ST_DEV);
    wire accept = in_dev ? dev_match : (in_wdat ? wr_ok : 1'b1);
    // each byte is queued on its own, never held until STOP
    wire push = byte_done & in_wdat & wr_ok;
    wire ack_begin = ack_pend_ff & scl_fall;
    wire ack_end = ack_phase_ff & scl_fall;
    wire [2:0] tx_idx = 3'(`ISM_BIT_LAST - bit_cnt_ff);

    // successor after our acknowledge: header picks read or write
    ism_pkg::ism_state_t after_ack;
    assign after_ack = in_dev ? (rd_ff ? ism_pkg::ST_RDAT : ism_pkg::ST_AHI)
                     : (state_ff == ism_pkg::ST_AHI) ? ism_pkg::ST_ALO
                     : ism_pkg::ST_WDAT;

    // write queue fill side
    assign wr_if.valid = push;
    assign wr_if.data = {addr_ff, rx_byte};

    ism_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .fill_if(wr_if),
        .drain_if(mem_if)
    );

    // a read fetch owns the array port for its cycle and stalls the drain;
    // queued writes leave within a few cycles, long before a read header ends
    assign mem_if.ready = ~fetch_ff;

    // ------------------------------------------------------------
    // protocol sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_addr = addr_ff;
        nxt_hi = hi_ff;
        nxt_rd = rd_ff;
        nxt_ack_pend = ack_pend_ff;
        nxt_ack_phase = ack_phase_ff;
        nxt_drive = drive_ff;
        nxt_fetch = 1'b0;
        if (start_det | stop_det) begin
            // partial byte dropped, address latch kept for a random read
            nxt_state = start_det ? ism_pkg::ST_DEV : ism_pkg::ST_IDLE;
            nxt_bit_cnt = 4'h0;
            nxt_ack_pend = 1'b0;
            nxt_ack_phase = 1'b0;
            nxt_drive = 1'b0;
        end else if (ack_begin) begin
            nxt_ack_pend = 1'b0;
            nxt_ack_phase = 1'b1;
            nxt_drive = 1'b1;
        end else if (ack_end) begin
            nxt_ack_phase = 1'b0;
            nxt_bit_cnt = 4'h0;
            nxt_state = after_ack;
            // first read bit goes out on the fall that ends the header ack
            nxt_drive = (after_ack == ism_pkg::ST_RDAT) ? ~tx_ff[7] : 1'b0;
        end else if (rx_bit) begin
            nxt_shift = rx_byte;
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (byte_done) begin
                nxt_ack_pend = accept;
                nxt_state = accept ? state_ff : ism_pkg::ST_IDLE;
                if (in_dev) begin
                    nxt_rd = rx_byte[`ISM_SA_DIR];
                    nxt_fetch = dev_match & rx_byte[`ISM_SA_DIR];
                end
                if (state_ff == ism_pkg::ST_AHI) begin
                    nxt_hi = rx_byte[HI_W-1:0]; // top bits ignored
                end
                if (state_ff == ism_pkg::ST_ALO) begin
                    nxt_addr = {hi_ff, rx_byte}; // loaded even with no data
                end
                if (push) begin
                    nxt_addr = addr_next(addr_ff); // refused bytes keep it
                end
            end
        end else if (state_ff == ism_pkg::ST_RDAT) begin
            if (scl_fall) begin
                if (bit_cnt_ff == `ISM_BIT_ACK) begin
                    // release for the master ack, step and prefetch
                    nxt_drive = 1'b0;
                    nxt_addr = addr_next(addr_ff);
                    nxt_fetch = 1'b1;
                end else if (bit_cnt_ff == `ISM_BIT_WAIT) begin
                    // acknowledged: next byte goes out whatever follows
                    nxt_bit_cnt = 4'h0;
                    nxt_drive = ~tx_ff[7];
                end else begin
                    nxt_drive = ~tx_ff[tx_idx];
                end
            end else if (scl_rise) begin
                if (bit_cnt_ff == `ISM_BIT_ACK) begin
                    // no-ack ends the read and waits for START
                    nxt_state = sda_s ? ism_pkg::ST_IDLE : state_ff;
                    nxt_bit_cnt = `ISM_BIT_WAIT;
                end else begin
                    nxt_bit_cnt = bit_cnt_ff + 4'h1;
                end
            end
        end
    end

    // register bank of the sequencer
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ism_pkg::ST_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            addr_ff <= '0;
            hi_ff <= '0;
            rd_ff <= 1'b0;
            ack_pend_ff <= 1'b0;
            ack_phase_ff <= 1'b0;
            drive_ff <= 1'b0;
            fetch_ff <= 1'b0;
            sda_o_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            addr_ff <= nxt_addr;
            hi_ff <= nxt_hi;
            rd_ff <= nxt_rd;
            ack_pend_ff <= nxt_ack_pend;
            ack_phase_ff <= nxt_ack_phase;
            drive_ff <= nxt_drive;
            fetch_ff <= nxt_fetch;
            sda_o_ff <= 1'b0; // open drain: only ever pulls low
        end
    end

    // ------------------------------------------------------------
    // array: queued writes and one-cycle read fetch
    // ------------------------------------------------------------
    // commit lands a few cycles after the eighth bit, well before the ack fall
    always_ff @(posedge clk_i) begin
        if (mem_if.valid & mem_if.ready) begin
            mem_ff[mem_if.data[WORD_W-1:8]] <= mem_if.data[7:0];
        end
    end

    // read data buffer, loaded at the current latch value
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tx_ff <= 8'h00;
        end else if (fetch_ff) begin
            tx_ff <= mem_ff[addr_ff];
        end
    end

    assign sda_o = sda_o_ff;
    assign sda_oe_o = drive_ff;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    a_wp_no_push: assert property (
        byte_done && in_wdat && wp_s |-> !wr_if.valid ##1 state_ff == ism_pkg::ST_IDLE
    ) else $error("protected byte was queued or acknowledged");

    a_wp_addr_hold: assert property (
        byte_done && in_wdat && wp_s |=> addr_ff == $past(addr_ff)
    ) else $error("address moved on a protected byte");

    a_write_wrap: assert property (
        push && addr_ff == '1 |=> addr_ff == '0
    ) else $error("write address did not wrap to zero");

    a_read_step: assert property (
        state_ff == ism_pkg::ST_RDAT && scl_fall && bit_cnt_ff == `ISM_BIT_ACK && !stop_det
        && !start_det |=> addr_ff == addr_next($past(addr_ff)) && !sda_oe_o ##1 fetch_ff == 1'b0
    ) else $error("read byte did not advance address and release the line");

    a_start_release: assert property (
        start_det |=> state_ff == ism_pkg::ST_DEV && !sda_oe_o && bit_cnt_ff == 4'h0
    ) else $error("start did not restart the header");

    a_stop_release: assert property (
        stop_det |=> state_ff == ism_pkg::ST_IDLE && !sda_oe_o && !ack_pend_ff
    ) else $error("stop did not free the bus");

    a_commit_first: assert property (
        push |-> ##[1:6] !mem_if.valid
    ) else $error("write not committed soon after the eighth bit");

    a_no_match_idle: assert property (
        byte_done && in_dev && !dev_match |=> state_ff == ism_pkg::ST_IDLE && !ack_pend_ff
    ) else $error("foreign header was answered");

    a_addr_load: assert property (
        byte_done && state_ff == ism_pkg::ST_ALO |=> addr_ff == {$past(hi_ff), $past(rx_byte)}
        && ack_pend_ff
    ) else $error("address bytes not latched and acknowledged");

    a_nack_ends: assert property (
        state_ff == ism_pkg::ST_RDAT && scl_rise && bit_cnt_ff == `ISM_BIT_ACK && sda_s
        && !stop_det && !start_det |=> state_ff == ism_pkg::ST_IDLE [*2]
    ) else $error("read continued after a no-acknowledge");
endmodule : ism_top

// [test/ism_master_model.sv]
// behavioural two-wire bus master that drives the serial memory slave
`timescale 1ns/1ps
module ism_master_model (
    input wire logic clk_i,
    input wire logic sda_line_i,
    output logic scl_o,
    output logic sda_o,
    output logic res_stb_o,
    output logic res_is_byte_o,
    output logic [7:0] res_byte_o
);
    // ----------------------------------------------------------------
    // line drivers and bus conditions
    // ----------------------------------------------------------------
    logic seen;

    // clock stands high and data is released outside frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        seen = 1'b1;
        res_stb_o = 1'b0;
        res_is_byte_o = 1'b0;
        res_byte_o = 8'h00;
    end

    // a quarter bit is 5 clocks; steps land just after a clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    // hands one result to the bench monitor
    task automatic report(input logic is_byte, input logic [7:0] v);
        res_is_byte_o = is_byte;
        res_byte_o = v;
        res_stb_o = 1'b1;
        tick(1); // keeps every line change just after a clock edge
        res_stb_o = 1'b0;
    endtask : report

    // also serves as a repeated start while the clock is low
    task automatic start_cond();
        sda_o = 1'b1;
        tick(5);
        scl_o = 1'b1;
        tick(5);
        sda_o = 1'b0;
        tick(5);
        scl_o = 1'b0;
        tick(5);
    endtask : start_cond

    // leaves the clock high so it stands still until the next frame
    task automatic stop_cond();
        sda_o = 1'b0;
        tick(5);
        scl_o = 1'b1;
        tick(5);
        sda_o = 1'b1;
        tick(5);
    endtask : stop_cond

    // data held 40 ns either side of each clock edge, sampled mid-high
    task automatic bit_cycle(input logic b);
        sda_o = b;
        tick(5);
        scl_o = 1'b1;
        tick(5);
        seen = sda_line_i;
        tick(5);
        scl_o = 1'b0;
        tick(5);
    endtask : bit_cycle

    // fewer than 8 bits lets a caller cut a byte short
    task automatic wbits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            bit_cycle(b[i]);
        end
    endtask : wbits

    task automatic wbyte(input logic [7:0] b);
        wbits(b, 8);
        bit_cycle(1'b1);
        report(1'b0, {7'h00, ~seen});
    endtask : wbyte

    // with mack low the ninth clock is left to the caller
    task automatic rbyte(input logic mack);
        logic [7:0] v;
        v = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1);
            v[i] = seen;
        end
        report(1'b1, v);
        if (mack) begin
            bit_cycle(1'b0);
        end
    endtask : rbyte
endmodule : ism_master_model

// [test/tb_top.sv]
// self-checking bench of the serial memory slave against a bus master model
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic is_byte; logic [7:0] val;} ism_exp_t;
    localparam logic [3:0] DEV = 4'h3; // arbitrary type code for this bench
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp = 1'b0;
    logic [2:0] cs = 3'h0;
    logic m_scl, m_sda, sda_line, dut_sda, dut_oe, res_stb, res_is_byte;
    logic [7:0] res_byte;
    logic [7:0] ref_mem [0:8191];
    logic [12:0] cur_addr = 13'h0000;
    ism_exp_t exp_q [$];
    ism_exp_t cur_exp;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    // ----------------------------------------------------------------
    // clock, wire and instances
    // ----------------------------------------------------------------
    always #4 clk = ~clk;
    // pull-up wire: low when either party pulls it
    assign sda_line = m_sda & (dut_oe ? dut_sda : 1'b1);

    ism_top #(.DEV_TYPE(DEV)) uut (.clk_i(clk), .reset_n_i(reset_n), .scl_i(m_scl),
        .sda_i(sda_line), .sda_o(dut_sda), .sda_oe_o(dut_oe), .chip_select_pins_i(cs),
        .wp_i(wp));
    ism_master_model m (.clk_i(clk), .sda_line_i(sda_line), .scl_o(m_scl), .sda_o(m_sda),
        .res_stb_o(res_stb), .res_is_byte_o(res_is_byte), .res_byte_o(res_byte));

    // ----------------------------------------------------------------
    // comparison, reporting and result monitor
    // ----------------------------------------------------------------
    task automatic cmp_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask : cmp_byte

    task automatic cmp_ack(input string name, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %b seen %b", name, e, g);
        end
    endtask : cmp_ack

    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    // oldest note is matched against each result the master reports
    always @(posedge res_stb) begin
        if (exp_q.size() == 0) begin
            bad_count++;
            $display("unexpected result %h with nothing noted", res_byte);
        end else begin
            cur_exp = exp_q.pop_front();
            if (cur_exp.is_byte) begin
                cmp_byte("read byte", cur_exp.val, res_byte);
            end else begin
                cmp_ack("ack", cur_exp.val[0], res_byte[0]);
            end
        end
    end

    // a hang is cut short well above the expected run length
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            $display("unexpected timeout: expected done seen running");
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // transfer tasks
    // ----------------------------------------------------------------
    task automatic send(input logic [7:0] b, input logic ack);
        exp_q.push_back('{1'b0, {7'h00, ack}});
        m.wbyte(b);
    endtask : send

    task automatic header(input logic [15:0] a);
        m.start_cond();
        send({DEV, cs, 1'b0}, 1'b1);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
        cur_addr = a[12:0];
    endtask : header

    task automatic wr_seq(input logic [15:0] a, input int n, input logic prot);
        logic [7:0] d;
        header(a);
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            if (prot) begin
                send(d, 1'b0);
                break;
            end
            ref_mem[cur_addr] = d;
            send(d, 1'b1);
            cur_addr = cur_addr + 13'h0001;
        end
        m.stop_cond();
    endtask : wr_seq

    // term: 0 nack+stop, 1 nack+start, 2 stop in 9th, 3 start in 9th clock
    task automatic rd_seq(input logic [15:0] a, input logic set, input int n, input int term);
        if (set) begin
            header(a);
        end
        m.start_cond();
        send({DEV, cs, 1'b1}, 1'b1);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back('{1'b1, ref_mem[cur_addr]});
            cur_addr = cur_addr + 13'h0001;
            m.rbyte(i < n - 1);
        end
        if (term < 2) begin
            m.bit_cycle(1'b1);
        end
        if (term % 2 == 1) begin
            m.start_cond();
        end
        m.stop_cond();
        cmp_ack("line released", 1'b0, dut_oe);
    endtask : rd_seq

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'he14a));
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        cs = 3'($urandom);
        // probes with every select value, then a wrong type code
        for (int s = 0; s < 8; s++) begin
            m.start_cond();
            send({DEV, 3'(s), 1'b0}, 3'(s) == cs);
            m.stop_cond();
        end
        m.start_cond();
        send({~DEV, cs, 1'b0}, 1'b0);
        m.stop_cond();
        // write across the top of the array, then read back every way of ending
        wr_seq(16'hFFFE, 11, 1'b0);
        for (int t = 0; t < 4; t++) begin
            rd_seq(16'hFFFE, t == 0, (t == 0) ? 3 : 2, t);
        end
        // a byte cut short by STOP or START leaves its location alone;
        // the condition's own clock rise counts as a bit, so stay below seven
        for (int k = 0; k < 2; k++) begin
            header(16'h0003);
            m.wbits(8'($urandom), 5 + k);
            if (k == 1) begin
                m.start_cond();
            end
            m.stop_cond();
            rd_seq(16'h0003, 1'b1, 1, 0);
        end
        // protected write is refused and the counter stays put
        wp = 1'b1;
        wr_seq(16'h0004, 1, 1'b1);
        rd_seq(16'h0000, 1'b0, 2, 2);
        wp = 1'b0;
        wr_seq(16'h0004, 2, 1'b0);
        rd_seq(16'h0004, 1'b1, 2, 0);
        if (exp_q.size() != 0) begin
            bad_count++;
            $display("unexpected pending notes: expected 0 seen %0d", exp_q.size());
        end
        close_out();
    end
endmodule : tb_top
